// *** dsr_regs.vh ***
// Notes on behaviour
// RULE_01 - Two independent eight-stage shift registers, sixteen stages in all, each clock moving bits one stage toward the last.
// RULE_02 - Each register shows its last stage on a true output and on an inverted output.
// RULE_03 - Stages change only on a rising edge of their clock, never on a falling one.
// RULE_04 - Each register has its own clock line, and a shared clock line steps both registers together.
// RULE_05 - The first stage takes the first serial input when select is 0 and the second when select is 1.
// RULE_06 - A shared active-low reset forces every stage to 0 whatever the select and data inputs; at 1 shifting proceeds.
// RULE_07 - A register's clock is the OR of its own and the shared clock line, and the unused line is held at 0.
`ifndef DSR_REGS_VH
`define DSR_REGS_VH
`define DSR_STAGES 8
`define DSR_NUM_REGS 2
`define DSR_RESET_VAL 8'h00
`define DSR_FIFO_DEPTH 4
`endif

// *** dsr_fifo.v ***
`timescale 1ns/1ps
module dsr_fifo #(
	parameter WIDTH = 2,
	parameter DEPTH = 4,
	parameter AW = 2
)(
	input wire clk_i,
	input wire reset_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output reg out_valid_o,
	input wire out_ready_i,
	output reg [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wp_r;
	reg [AW-1:0] rp_r;
	reg [AW:0] cnt_r;
	wire push;
	wire pop;
	localparam [AW:0] FULL_CNT = DEPTH;
	assign in_ready_o = (cnt_r != FULL_CNT);
	assign push = in_valid_i && in_ready_o;
	// output register refills whenever it is empty or being drained and the fifo holds an entry
	assign pop = (cnt_r != {(AW+1){1'b0}}) && (!out_valid_o || out_ready_i);
	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			wp_r <= {AW{1'b0}};
			rp_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
			out_valid_o <= 1'b0;
			out_data_o <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem_r[wp_r] <= in_data_i;
				wp_r <= wp_r + 1'b1;
			end
			if (pop)
			begin
				out_data_o <= mem_r[rp_r];
				rp_r <= rp_r + 1'b1;
				out_valid_o <= 1'b1;
			end
			else if (out_ready_i)
				out_valid_o <= 1'b0;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule // dsr_fifo

// *** dsr_top.v ***
`timescale 1ns/1ps
`include "dsr_regs.vh"
module dsr_top #(
	parameter STAGES = `DSR_STAGES
)(
	input wire clk_i,
	input wire reset_i,
	input wire reset_n_i,
	input wire input_select_i,
	input wire [1:0] data0_i,
	input wire [1:0] data1_i,
	input wire [1:0] per_register_clock_i,
	input wire common_clock_i,
	output reg [1:0] last_o,
	output reg [1:0] last_n_o,
	output reg [STAGES*2-1:0] stages_o
);
	// shift clocks are pins sampled on clk_i; their rises become enables
	reg [1:0] sclk_prev_r;
	reg [1:0] sel_d_r;
	reg [1:0] step_r;
	wire [1:0] sclk;
	wire [1:0] rise;
	wire [1:0] fifo_vld;
	wire [1:0] fifo_dat;
	wire [1:0] fifo_rdy;
	genvar g;

	assign sclk = per_register_clock_i | {2{common_clock_i}}; // RULE_07 RULE_04
	assign rise = sclk & ~sclk_prev_r; // RULE_03

	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			sclk_prev_r <= 2'h0;
			sel_d_r <= 2'h0;
			step_r <= 2'h0;
		end
		else
		begin
			sclk_prev_r <= sclk;
			step_r <= rise & fifo_rdy;
			sel_d_r[0] <= input_select_i ? data1_i[0] : data0_i[0]; // RULE_05
			sel_d_r[1] <= input_select_i ? data1_i[1] : data0_i[1]; // RULE_05
		end
	end

	// selected bits ride a small fifo so a burst of edges is not lost
	dsr_fifo #(
		.WIDTH(1),
		.DEPTH(`DSR_FIFO_DEPTH),
		.AW(2)
	) u_fifo0 (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.in_valid_i(step_r[0]),
		.in_ready_o(fifo_rdy[0]),
		.in_data_i(sel_d_r[0]),
		.out_valid_o(fifo_vld[0]),
		.out_ready_i(1'b1),
		.out_data_o(fifo_dat[0])
	);
	dsr_fifo #(
		.WIDTH(1),
		.DEPTH(`DSR_FIFO_DEPTH),
		.AW(2)
	) u_fifo1 (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.in_valid_i(step_r[1]),
		.in_ready_o(fifo_rdy[1]),
		.in_data_i(sel_d_r[1]),
		.out_valid_o(fifo_vld[1]),
		.out_ready_i(1'b1),
		.out_data_o(fifo_dat[1])
	);

	generate
		for (g = 0; g < `DSR_NUM_REGS; g = g + 1)
		begin : g_reg
			always @(posedge clk_i)
			begin
				if (reset_i || !reset_n_i) // RULE_06
				begin
					stages_o[g*STAGES +: STAGES] <= {STAGES{1'b0}};
					last_o[g] <= 1'b0;
					last_n_o[g] <= 1'b1;
				end
				else if (fifo_vld[g])
				begin
					stages_o[g*STAGES +: STAGES] <= // RULE_01
						{stages_o[g*STAGES +: STAGES-1], fifo_dat[g]};
					last_o[g] <= stages_o[g*STAGES+STAGES-2]; // RULE_02
					last_n_o[g] <= ~stages_o[g*STAGES+STAGES-2]; // RULE_02
				end
			end
		end
	endgenerate
endmodule // dsr_top

// *** dsr_top_chk.sv ***
`timescale 1ns/1ps
module dsr_top_chk (
	input wire clk_i,
	input wire reset_i,
	input wire reset_n_i,
	input wire input_select_i,
	input wire [1:0] data0_i,
	input wire [1:0] data1_i,
	input wire [1:0] per_register_clock_i,
	input wire common_clock_i,
	input wire [1:0] last_o,
	input wire [1:0] last_n_o,
	input wire [15:0] stages_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire c0 = per_register_clock_i[0] | common_clock_i;
	wire c1 = per_register_clock_i[1] | common_clock_i;
	wire [1:0] lst = {stages_o[15], stages_o[7]};
	property p_out; last_o == lst && last_n_o == ~lst; endproperty
	a_out: assert property (p_out) else $error("bad last");
	property p_rst; !reset_n_i |=> stages_o == 16'h0; endproperty
	a_rst: assert property (p_rst) else $error("no clear");
	property p_in; logic d; ($rose(c0) && reset_n_i, d = input_select_i ?
		data1_i[0] : data0_i[0]) |-> ##4 stages_o[0] == d; endproperty
	a_in: assert property (p_in) else $error("bad entry");
	property p_in1; logic d; ($rose(c1) && reset_n_i, d = input_select_i ?
		data1_i[1] : data0_i[1]) |-> ##4 stages_o[8] == d; endproperty
	a_in1: assert property (p_in1) else $error("bad entry one");
	property p_shift; logic [6:0] v; ($rose(c0) && reset_n_i) |-> ##3
		(1'b1, v = stages_o[6:0]) ##1 stages_o[7:1] == v; endproperty
	a_shift: assert property (p_shift) else $error("bad shift");
	property p_clr;
		!reset_n_i |=> last_o == 2'h0 && last_n_o == 2'h3;
	endproperty
	a_clr: assert property (p_clr) else $error("last not cleared");
endmodule // dsr_top_chk

// *** dsr_board.sv ***
`timescale 1ns/1ps
module dsr_board (
	input wire clk_i,
	input wire [2:0] pulse_i,
	output logic [2:0] line_o = 3'h0
);
	// one-cycle pulses only, so an idle line sits at 0
	always @(posedge clk_i)
		line_o <= pulse_i;
endmodule // dsr_board

// *** dsr_top_bench.sv ***
`timescale 1ns/1ps
module dsr_top_bench;
	logic clk_i = 0, reset_i = 1, reset_n_i = 0, input_select_i = 0;
	logic [1:0] data0_i = 0, data1_i = 0, last_o, last_n_o;
	logic [2:0] pulse = 0, ln;
	logic [4:0] dl = 0;
	logic [15:0] stages_o, m = 0;
	logic [19:0] q[$];
	logic [31:0] s = 32'h62CFE36A;
	int n_mismatch = 0, checked = 0;
	wire [19:0] got = {last_n_o, last_o, stages_o};
	always #5 clk_i = ~clk_i;
	dsr_board dsr_board_i (.clk_i, .pulse_i(pulse), .line_o(ln));
	dsr_top dsr_top_i (.clk_i, .reset_i, .reset_n_i, .input_select_i,
		.data0_i, .data1_i, .per_register_clock_i(ln[1:0]),
		.common_clock_i(ln[2]), .last_o, .last_n_o, .stages_o);
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task tally_and_finish;
		if (n_mismatch == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task step(input logic [1:0] k);
		logic [1:0] d;
		logic [2:0] p;
		@(posedge clk_i);
		s = xs(s);
		d = s[0] ? s[4:3] : s[2:1];
		p = k[0] ? {s[6], ~s[6] & s[5], ~s[6] & ~s[5]} : 3'h0;
		if (p[0] | p[2]) m[7:0] = {m[6:0], d[0]};
		if (p[1] | p[2]) m[15:8] = {m[14:8], d[1]};
		if (!k[1]) m = 16'h0;
		if (p) q.push_back({~m[15], ~m[7], m[15], m[7], m});
		reset_n_i <= k[1];
		pulse <= p;
		input_select_i <= s[0];
		data0_i <= s[2:1];
		data1_i <= s[4:3];
		@(posedge clk_i) pulse <= 3'h0;
		@(posedge clk_i);
	endtask
	task cmp(input logic [19:0] x);
		checked++;
		if (got !== x)
		begin
			n_mismatch++;
			$display("CHECK FAILED outputs %h %h", x, got);
		end
	endtask
	// the result shows four edges after the pin sees the rise
	always @(posedge clk_i)
	begin
		dl <= {dl[3:0], |pulse};
		if (dl[4])
			cmp(q.pop_front());
	end
	initial
	begin
		repeat (5) @(posedge clk_i);
		reset_i <= 1'h0;
		repeat (30) step(2'h3);
		step(2'h2);
		step(2'h0);
		repeat (20) step(2'h3);
		repeat (2) step(2'h2);
		tally_and_finish;
	end
	initial
	begin
		#5000 n_mismatch++;
		tally_and_finish;
	end
endmodule // dsr_top_bench
bind dsr_top dsr_top_chk dsr_top_chk_i (.*);
